// [verilog/io_pin_function_mux.sv]
// What this block does
// - Each pad takes one of three functions
// - Matrix-routed function reaches general internal signals
// - Direct functions reach UART, JTAG, SPI ports
// - Matrix, fast and flash data functions have input/output/float capability
// - Unselected pull-high inputs read constant one
// - Unselected pull-low inputs read constant zero
// - Pad 4: JTAG mode, matrix, fast hold
// - Pad 5: JTAG in, matrix, fast write-protect
// - Pad 6: JTAG clock, matrix, fast clock
// - Pad 7: JTAG out, matrix, fast data-in
// - Pads 2, 10: fast data-out, chip select
// - Pads 12, 13: flash hold, write-protect
// - Pads 14, 15: flash chip select, clock
// - Pads 16, 17: flash data-in, data-out
// - Pads 20, 21: UART receive, transmit
// - Other pads: matrix, or USB on pads 18, 19 while enabled; no function two
// - Flash lines support one, two, four lanes
// - Fast lines support one, two, four lanes
module io_pin_function_mux (
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RST,
   // Pad side
   input wire logic [pin_mux_pkg::PAD_COUNT-1:0] PAD_IN,
   output logic [pin_mux_pkg::PAD_COUNT-1:0] PAD_OUT,
   output logic [pin_mux_pkg::PAD_COUNT-1:0] PAD_OE_N,
   // Configuration
   input wire pin_mux_pkg::sel_type [pin_mux_pkg::PAD_COUNT-1:0] FUNC_SEL,
   input wire logic USB_ENABLE,
   // Routing matrix side
   input wire logic [pin_mux_pkg::PAD_COUNT-1:0] MATRIX_OUT,
   input wire logic [pin_mux_pkg::PAD_COUNT-1:0] MATRIX_OE,
   output logic [pin_mux_pkg::PAD_COUNT-1:0] MATRIX_IN,
   // JTAG
   output pin_mux_pkg::jtag_in_type JTAG_IN,
   input wire logic JTAG_SERIAL_OUT,
   input wire logic JTAG_SERIAL_OE,
   // Flash port
   input wire pin_mux_pkg::spi_lines_type FLASH_OUT,
   input wire pin_mux_pkg::spi_lines_type FLASH_OE,
   output pin_mux_pkg::spi_lines_type FLASH_IN,
   // Fast port
   input wire pin_mux_pkg::spi_lines_type FAST_OUT,
   input wire pin_mux_pkg::spi_lines_type FAST_OE,
   output pin_mux_pkg::spi_lines_type FAST_IN,
   // UART zero
   input wire logic UART_ZERO_TRANSMIT,
   output logic UART_ZERO_RECEIVE,
   // USB lines, bit 1 plus, bit 0 minus
   output logic [1:0] USB_LINE_IN
);

   localparam int N = pin_mux_pkg::PAD_COUNT;

   // Pad synchroniser stages; first stage feeds only the second
   logic [N-1:0] pad_meta_q;
   logic [N-1:0] pad_sync_q;
   // Registered outputs and their next values
   logic [N-1:0] pad_out_q, pad_out_d;
   logic [N-1:0] pad_oe_n_q, pad_oe_n_d;
   logic [N-1:0] matrix_in_q, matrix_in_d;
   pin_mux_pkg::jtag_in_type jtag_q, jtag_d;
   pin_mux_pkg::spi_lines_type flash_in_q, flash_in_d;
   pin_mux_pkg::spi_lines_type fast_in_q, fast_in_d;
   logic uart_rx_q, uart_rx_d;
   logic [1:0] usb_q, usb_d;

   // Function table: which source a pad connects to for a select
   function automatic pin_mux_pkg::src_type pad_source(input int pad, input pin_mux_pkg::sel_type sel,
                                                       input logic usb_on);
      pin_mux_pkg::src_type f0;
      pin_mux_pkg::src_type f2;
      f0 = pin_mux_pkg::SRC_MATRIX;
      f2 = pin_mux_pkg::SRC_NONE;
      case (pad)
         2: f2 = pin_mux_pkg::SRC_FAST_DOUT;
         4: begin
            f0 = pin_mux_pkg::SRC_JTAG_MODE;
            f2 = pin_mux_pkg::SRC_FAST_HOLD;
         end
         5: begin
            f0 = pin_mux_pkg::SRC_JTAG_IN;
            f2 = pin_mux_pkg::SRC_FAST_WP;
         end
         6: begin
            f0 = pin_mux_pkg::SRC_JTAG_CLOCK;
            f2 = pin_mux_pkg::SRC_FAST_CLOCK;
         end
         7: begin
            f0 = pin_mux_pkg::SRC_JTAG_OUT;
            f2 = pin_mux_pkg::SRC_FAST_DIN;
         end
         10: f2 = pin_mux_pkg::SRC_FAST_CS;
         12: f0 = pin_mux_pkg::SRC_FLASH_HOLD;
         13: f0 = pin_mux_pkg::SRC_FLASH_WP;
         14: f0 = pin_mux_pkg::SRC_FLASH_CS;
         15: f0 = pin_mux_pkg::SRC_FLASH_CLOCK;
         16: f0 = pin_mux_pkg::SRC_FLASH_DIN;
         17: f0 = pin_mux_pkg::SRC_FLASH_DOUT;
         20: f0 = pin_mux_pkg::SRC_UART_RX;
         21: f0 = pin_mux_pkg::SRC_UART_TX;
         default: f0 = pin_mux_pkg::SRC_MATRIX;
      endcase
      // Analog USB takes over pads 18 and 19 while enabled
      if (usb_on && (pad == pin_mux_pkg::USB_MINUS_PAD || pad == pin_mux_pkg::USB_PLUS_PAD)) begin
         pad_source = pin_mux_pkg::SRC_USB;
      end else if (sel == pin_mux_pkg::PAD_FUNCTION_ZERO) begin
         pad_source = f0;
      end else if (sel == pin_mux_pkg::PAD_FUNCTION_ONE) begin
         pad_source = pin_mux_pkg::SRC_MATRIX;
      end else if (sel == pin_mux_pkg::PAD_FUNCTION_TWO) begin
         pad_source = f2;
      end else begin
         pad_source = pin_mux_pkg::SRC_NONE;
      end
   endfunction

   // Pads come from outside: two flops before any logic
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         pad_meta_q <= {N{pin_mux_pkg::SYNC_RESET}};
         pad_sync_q <= {N{pin_mux_pkg::SYNC_RESET}};
      end else begin
         pad_meta_q <= PAD_IN;
         pad_sync_q <= pad_meta_q;
      end
   end

   // Route every pad; unselected inputs fall to their fixed level
   always_comb begin
      pin_mux_pkg::src_type src;
      src = pin_mux_pkg::SRC_NONE;
      pad_out_d = {N{pin_mux_pkg::PAD_OUT_RESET}};
      pad_oe_n_d = {N{pin_mux_pkg::PAD_OE_N_RESET}};
      matrix_in_d = {N{pin_mux_pkg::MATRIX_IN_RESET}};
      jtag_d = '{default: pin_mux_pkg::PULL_HIGH_RESET};
      flash_in_d = '{default: pin_mux_pkg::PULL_HIGH_RESET};
      fast_in_d = '{default: pin_mux_pkg::PULL_HIGH_RESET};
      uart_rx_d = pin_mux_pkg::PULL_HIGH_RESET;
      usb_d = 2'h0;
      for (int i = 0; i < N; i++) begin
         src = pad_source(i, FUNC_SEL[i], USB_ENABLE);
         case (src)
            // Matrix gets the pad and may drive it
            pin_mux_pkg::SRC_MATRIX: begin
               pad_out_d[i] = MATRIX_OUT[i];
               pad_oe_n_d[i] = !MATRIX_OE[i];
               matrix_in_d[i] = pad_sync_q[i];
            end
            // Analog lines: digital side lets go of the pad
            pin_mux_pkg::SRC_USB: begin
               if (i == pin_mux_pkg::USB_PLUS_PAD) begin
                  usb_d[1] = pad_sync_q[i];
               end else begin
                  usb_d[0] = pad_sync_q[i];
               end
            end
            // JTAG inputs only
            pin_mux_pkg::SRC_JTAG_MODE: jtag_d.mode_select = pad_sync_q[i];
            pin_mux_pkg::SRC_JTAG_IN: jtag_d.serial_in = pad_sync_q[i];
            pin_mux_pkg::SRC_JTAG_CLOCK: jtag_d.test_clock = pad_sync_q[i];
            // JTAG output or float, no input path
            pin_mux_pkg::SRC_JTAG_OUT: begin
               pad_out_d[i] = JTAG_SERIAL_OUT;
               pad_oe_n_d[i] = !JTAG_SERIAL_OE;
            end
            // Fast port: every line two-way so quad mode works
            pin_mux_pkg::SRC_FAST_HOLD: begin
               pad_out_d[i] = FAST_OUT.hold;
               pad_oe_n_d[i] = !FAST_OE.hold;
               fast_in_d.hold = pad_sync_q[i];
            end
            pin_mux_pkg::SRC_FAST_WP: begin
               pad_out_d[i] = FAST_OUT.write_protect;
               pad_oe_n_d[i] = !FAST_OE.write_protect;
               fast_in_d.write_protect = pad_sync_q[i];
            end
            pin_mux_pkg::SRC_FAST_CLOCK: begin
               pad_out_d[i] = FAST_OUT.clock;
               pad_oe_n_d[i] = !FAST_OE.clock;
               fast_in_d.clock = pad_sync_q[i];
            end
            pin_mux_pkg::SRC_FAST_CS: begin
               pad_out_d[i] = FAST_OUT.chip_select;
               pad_oe_n_d[i] = !FAST_OE.chip_select;
               fast_in_d.chip_select = pad_sync_q[i];
            end
            pin_mux_pkg::SRC_FAST_DIN: begin
               pad_out_d[i] = FAST_OUT.data_in;
               pad_oe_n_d[i] = !FAST_OE.data_in;
               fast_in_d.data_in = pad_sync_q[i];
            end
            pin_mux_pkg::SRC_FAST_DOUT: begin
               pad_out_d[i] = FAST_OUT.data_out;
               pad_oe_n_d[i] = !FAST_OE.data_out;
               fast_in_d.data_out = pad_sync_q[i];
            end
            // Flash port: four data lanes two-way
            pin_mux_pkg::SRC_FLASH_HOLD: begin
               pad_out_d[i] = FLASH_OUT.hold;
               pad_oe_n_d[i] = !FLASH_OE.hold;
               flash_in_d.hold = pad_sync_q[i];
            end
            pin_mux_pkg::SRC_FLASH_WP: begin
               pad_out_d[i] = FLASH_OUT.write_protect;
               pad_oe_n_d[i] = !FLASH_OE.write_protect;
               flash_in_d.write_protect = pad_sync_q[i];
            end
            // Flash select and clock: output or float only
            pin_mux_pkg::SRC_FLASH_CS: begin
               pad_out_d[i] = FLASH_OUT.chip_select;
               pad_oe_n_d[i] = !FLASH_OE.chip_select;
            end
            pin_mux_pkg::SRC_FLASH_CLOCK: begin
               pad_out_d[i] = FLASH_OUT.clock;
               pad_oe_n_d[i] = !FLASH_OE.clock;
            end
            pin_mux_pkg::SRC_FLASH_DIN: begin
               pad_out_d[i] = FLASH_OUT.data_in;
               pad_oe_n_d[i] = !FLASH_OE.data_in;
               flash_in_d.data_in = pad_sync_q[i];
            end
            pin_mux_pkg::SRC_FLASH_DOUT: begin
               pad_out_d[i] = FLASH_OUT.data_out;
               pad_oe_n_d[i] = !FLASH_OE.data_out;
               flash_in_d.data_out = pad_sync_q[i];
            end
            // UART receive is input only
            pin_mux_pkg::SRC_UART_RX: uart_rx_d = pad_sync_q[i];
            // UART transmit is a plain output, always driven
            pin_mux_pkg::SRC_UART_TX: begin
               pad_out_d[i] = UART_ZERO_TRANSMIT;
               pad_oe_n_d[i] = 1'h0;
            end
            // Unused select: pad floats
            default: pad_oe_n_d[i] = pin_mux_pkg::PAD_OE_N_RESET;
         endcase
      end
   end

   // Output registers; pads float during reset
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         pad_out_q <= {N{pin_mux_pkg::PAD_OUT_RESET}};
         pad_oe_n_q <= {N{pin_mux_pkg::PAD_OE_N_RESET}};
         matrix_in_q <= {N{pin_mux_pkg::MATRIX_IN_RESET}};
         jtag_q <= '{default: pin_mux_pkg::PULL_HIGH_RESET};
         flash_in_q <= '{default: pin_mux_pkg::PULL_HIGH_RESET};
         fast_in_q <= '{default: pin_mux_pkg::PULL_HIGH_RESET};
         uart_rx_q <= pin_mux_pkg::PULL_HIGH_RESET;
         usb_q <= 2'h0;
      end else begin
         pad_out_q <= pad_out_d;
         pad_oe_n_q <= pad_oe_n_d;
         matrix_in_q <= matrix_in_d;
         jtag_q <= jtag_d;
         flash_in_q <= flash_in_d;
         fast_in_q <= fast_in_d;
         uart_rx_q <= uart_rx_d;
         usb_q <= usb_d;
      end
   end

   // Every output straight from a flop
   assign PAD_OUT = pad_out_q;
   assign PAD_OE_N = pad_oe_n_q;
   assign MATRIX_IN = matrix_in_q;
   assign JTAG_IN = jtag_q;
   assign FLASH_IN = flash_in_q;
   assign FAST_IN = fast_in_q;
   assign UART_ZERO_RECEIVE = uart_rx_q;
   assign USB_LINE_IN = usb_q;

   // Checks; assertions all one cycle behind their cause, fast_quad_c and flash_read_c in the same cycle
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RST);

   matrix_drive_a: assert property (FUNC_SEL[0] == pin_mux_pkg::PAD_FUNCTION_ONE |=>
      PAD_OE_N[0] == !$past(MATRIX_OE[0]) && PAD_OUT[0] == $past(MATRIX_OUT[0]))
      else $error("matrix pad 0 not following matrix");
   mode_pull_high_a: assert property (FUNC_SEL[4] != pin_mux_pkg::PAD_FUNCTION_ZERO |=> JTAG_IN.mode_select)
      else $error("unselected mode select not held high");
   matrix_pull_low_a: assert property (FUNC_SEL[3] == pin_mux_pkg::PAD_FUNCTION_TWO |=> !MATRIX_IN[3])
      else $error("unselected matrix input not held low");
   jtag_in_route_a: assert property (FUNC_SEL[5] == pin_mux_pkg::PAD_FUNCTION_ZERO |=>
      JTAG_IN.serial_in == $past(pad_sync_q[5]))
      else $error("jtag serial in not from pad 5");
   fast_clock_a: assert property (FUNC_SEL[6] == pin_mux_pkg::PAD_FUNCTION_TWO |=>
      PAD_OUT[6] == $past(FAST_OUT.clock) && PAD_OE_N[6] == !$past(FAST_OE.clock))
      else $error("fast clock not on pad 6");
   jtag_out_float_a: assert property (FUNC_SEL[7] == pin_mux_pkg::PAD_FUNCTION_ZERO && !JTAG_SERIAL_OE |=>
      PAD_OE_N[7])
      else $error("jtag out drives while disabled");
   flash_cs_a: assert property (FUNC_SEL[14] == pin_mux_pkg::PAD_FUNCTION_ZERO |=>
      PAD_OUT[14] == $past(FLASH_OUT.chip_select))
      else $error("flash select not on pad 14");
   uart_tx_a: assert property (FUNC_SEL[21] == pin_mux_pkg::PAD_FUNCTION_ZERO |=>
      !PAD_OE_N[21] && PAD_OUT[21] == $past(UART_ZERO_TRANSMIT))
      else $error("uart transmit not driving pad 21");
   no_func_two_a: assert property (FUNC_SEL[8] == pin_mux_pkg::PAD_FUNCTION_TWO |=> PAD_OE_N[8])
      else $error("pad 8 driven with function two");
   usb_release_a: assert property (USB_ENABLE |=> PAD_OE_N[18] && PAD_OE_N[19])
      else $error("usb pads driven while usb enabled");

   tms_used_c: cover property (FUNC_SEL[4] == pin_mux_pkg::PAD_FUNCTION_ZERO ##1 !JTAG_IN.mode_select);
   fast_quad_c: cover property (FUNC_SEL[4] == pin_mux_pkg::PAD_FUNCTION_TWO && FAST_OE.hold
      && FUNC_SEL[5] == pin_mux_pkg::PAD_FUNCTION_TWO && FAST_OE.write_protect);
   flash_read_c: cover property (FUNC_SEL[16] == pin_mux_pkg::PAD_FUNCTION_ZERO && !FLASH_OE.data_in);
   usb_on_c: cover property (USB_ENABLE ##1 USB_LINE_IN == 2'h2);

endmodule

// [verilog/pin_mux_pkg.sv]
package pin_mux_pkg;

   // Pad count and select encoding
   localparam int PAD_COUNT = 22;
   localparam logic [1:0] PAD_FUNCTION_ZERO = 2'h0;
   localparam logic [1:0] PAD_FUNCTION_ONE = 2'h1;
   localparam logic [1:0] PAD_FUNCTION_TWO = 2'h2;

   // Pad numbers with a special role
   localparam int USB_MINUS_PAD = 18;
   localparam int USB_PLUS_PAD = 19;

   // Select width per pad
   typedef logic [1:0] sel_type;

   // One bit per SPI line; used for outputs, enables and inputs alike
   typedef struct packed {
      logic hold;
      logic write_protect;
      logic clock;
      logic chip_select;
      logic data_in;
      logic data_out;
   } spi_lines_type;

   // JTAG inputs taken from pads
   typedef struct packed {
      logic mode_select;
      logic serial_in;
      logic test_clock;
   } jtag_in_type;

   // Reset values of the registered outputs and the pad synchroniser
   localparam logic PAD_OUT_RESET = 1'h0;
   localparam logic PAD_OE_N_RESET = 1'h1;
   localparam logic MATRIX_IN_RESET = 1'h0;
   localparam logic PULL_HIGH_RESET = 1'h1;
   localparam logic SYNC_RESET = 1'h0;

   // What a pad is connected to for a given select
   typedef enum {
      SRC_NONE,
      SRC_MATRIX,
      SRC_USB,
      SRC_JTAG_MODE,
      SRC_JTAG_IN,
      SRC_JTAG_CLOCK,
      SRC_JTAG_OUT,
      SRC_FAST_HOLD,
      SRC_FAST_WP,
      SRC_FAST_CLOCK,
      SRC_FAST_CS,
      SRC_FAST_DIN,
      SRC_FAST_DOUT,
      SRC_FLASH_HOLD,
      SRC_FLASH_WP,
      SRC_FLASH_CLOCK,
      SRC_FLASH_CS,
      SRC_FLASH_DIN,
      SRC_FLASH_DOUT,
      SRC_UART_RX,
      SRC_UART_TX
   } src_type;

endpackage

// [dv/periph_model.sv]
// Far side of the pad mux: matrix and peripheral drivers, fed by one bench word
module periph_model (
   // Stimulus word, changed by the bench at the falling edge
   input wire logic [95:0] STIM,
   // Routing matrix drivers
   output logic [21:0] MATRIX_OUT,
   output logic [21:0] MATRIX_OE,
   // JTAG data out
   output logic JTAG_SERIAL_OUT,
   output logic JTAG_SERIAL_OE,
   // Flash and fast port drivers
   output pin_mux_pkg::spi_lines_type FLASH_OUT,
   output pin_mux_pkg::spi_lines_type FLASH_OE,
   output pin_mux_pkg::spi_lines_type FAST_OUT,
   output pin_mux_pkg::spi_lines_type FAST_OE,
   // UART transmit line
   output logic UART_ZERO_TRANSMIT
);
   timeunit 1ns;
   timeprecision 1ns;

   // Plain slices; the peripherals answer at once, so no hidden state here
   assign MATRIX_OUT = STIM[21:0];
   assign MATRIX_OE = STIM[43:22];
   assign JTAG_SERIAL_OUT = STIM[44];
   assign JTAG_SERIAL_OE = STIM[45];
   assign FLASH_OUT = STIM[51:46];
   assign FLASH_OE = STIM[57:52];
   assign FAST_OUT = STIM[63:58];
   assign FAST_OE = STIM[69:64];
   assign UART_ZERO_TRANSMIT = STIM[70];
endmodule

// [dv/tb_top.sv]
// Self-checking bench for the pad function mux
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;

   // Pad numbers of flash and fast lines, index is the struct bit
   localparam int FL[6] = '{17, 16, 14, 15, 13, 12};
   localparam int FS[6] = '{2, 7, 10, 6, 5, 4};
   // Clock, reset and bench-driven inputs
   logic clock = 1'h0;
   logic rst = 1'h1;
   logic [21:0] pad_in = 22'h0;
   pin_mux_pkg::sel_type [21:0] func_sel = '0;
   logic usb_en = 1'h0;
   logic [95:0] stim = 96'h0;
   logic [31:0] seed = 32'h1;
   int fail_count = 0;
   int check_count = 0;
   // Design outputs and model outputs
   logic [21:0] pad_out, pad_oe_n, m_in, m_out, m_oe;
   pin_mux_pkg::jtag_in_type j_in;
   pin_mux_pkg::spi_lines_type fl_in, fl_out, fl_oe, fs_in, fs_out, fs_oe;
   logic j_out, j_oe, u_tx, u_rx;
   logic [1:0] usb_in;

   // 20 MHz clock
   always #25 clock = ~clock;

   io_pin_function_mux u_io_pin_function_mux (.CLOCK(clock), .RST(rst), .PAD_IN(pad_in), .PAD_OUT(pad_out),
      .PAD_OE_N(pad_oe_n), .FUNC_SEL(func_sel), .USB_ENABLE(usb_en), .MATRIX_OUT(m_out), .MATRIX_OE(m_oe),
      .MATRIX_IN(m_in), .JTAG_IN(j_in), .JTAG_SERIAL_OUT(j_out), .JTAG_SERIAL_OE(j_oe), .FLASH_OUT(fl_out),
      .FLASH_OE(fl_oe), .FLASH_IN(fl_in), .FAST_OUT(fs_out), .FAST_OE(fs_oe), .FAST_IN(fs_in),
      .UART_ZERO_TRANSMIT(u_tx), .UART_ZERO_RECEIVE(u_rx), .USB_LINE_IN(usb_in));

   periph_model u_periph_model (.STIM(stim), .MATRIX_OUT(m_out), .MATRIX_OE(m_oe), .JTAG_SERIAL_OUT(j_out),
      .JTAG_SERIAL_OE(j_oe), .FLASH_OUT(fl_out), .FLASH_OE(fl_oe), .FAST_OUT(fs_out), .FAST_OE(fs_oe),
      .UART_ZERO_TRANSMIT(u_tx));

   // Xorshift source, fixed start so runs repeat
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Pads whose function zero is also matrix general IO
   function automatic bit is_gen(int p);
      return p inside {0, 1, 2, 3, 8, 9, 10, 11, 18, 19};
   endfunction

   // True when USB owns the pad, whatever the select says
   function automatic bit usb_pad(int p);
      return usb_en && (p == 18 || p == 19);
   endfunction

   // Expected pad drive; floating is the default for every other case
   function automatic void exp_pads(output logic [21:0] oe_n, output logic [21:0] val);
      logic [1:0] s;
      for (int p = 0; p < 22; p++) begin
         s = func_sel[p];
         oe_n[p] = 1'h1;
         val[p] = 1'h0;
         if (usb_pad(p)) begin
            continue;
         end
         if (s == 2'h1 || (s == 2'h0 && is_gen(p))) begin
            oe_n[p] = ~m_oe[p];
            val[p] = m_out[p];
         end else if (s == 2'h0 && p == 7) begin
            oe_n[p] = ~j_oe;
            val[p] = j_out;
         end else if (s == 2'h0 && p == 21) begin
            oe_n[p] = 1'h0;
            val[p] = u_tx;
         end
         for (int i = 0; i < 6; i++) begin
            if (s == 2'h0 && FL[i] == p) begin
               oe_n[p] = ~fl_oe[i];
               val[p] = fl_out[i];
            end
            if (s == 2'h2 && FS[i] == p) begin
               oe_n[p] = ~fs_oe[i];
               val[p] = fs_out[i];
            end
         end
      end
   endfunction

   // Single compare used for every kind of result
   task automatic chk(input string name, input logic [21:0] exp, input logic [21:0] got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Drive one set of inputs, then check drive after one edge and inputs after the synchronisers
   task automatic run_one(input bit fixed, input logic [1:0] k);
      logic [21:0] e_oe_n, e_val, e_mi;
      logic [5:0] e_fl, e_fs;
      logic [2:0] e_j;
      @(negedge clock);
      // Only the low bits of the random word reach the pads
      pad_in = 22'(rnd());
      stim = {rnd(), rnd(), rnd()};
      usb_en = rnd() < 32'h40000000;
      for (int p = 0; p < 22; p++) begin
         func_sel[p] = fixed ? k : 2'(rnd() >> 30);
      end
      @(negedge clock);
      exp_pads(e_oe_n, e_val);
      chk("pad_oe_n", e_oe_n, pad_oe_n);
      chk("pad_out", e_val & ~e_oe_n, pad_out & ~e_oe_n);
      repeat (3) @(negedge clock);
      for (int p = 0; p < 22; p++) begin
         e_mi[p] = !usb_pad(p) && (func_sel[p] == 2'h1 || (func_sel[p] == 2'h0 && is_gen(p))) && pad_in[p];
      end
      for (int i = 0; i < 6; i++) begin
         e_fl[i] = (i == 2 || i == 3 || func_sel[FL[i]] != 2'h0) ? 1'h1 : pad_in[FL[i]];
         e_fs[i] = func_sel[FS[i]] == 2'h2 ? pad_in[FS[i]] : 1'h1;
      end
      chk("matrix_in", e_mi, m_in);
      // Mode select, serial in, test clock from pads 4, 5, 6; pulled high otherwise
      e_j[2] = func_sel[4] == 2'h0 ? pad_in[4] : 1'h1;
      e_j[1] = func_sel[5] == 2'h0 ? pad_in[5] : 1'h1;
      e_j[0] = func_sel[6] == 2'h0 ? pad_in[6] : 1'h1;
      chk("jtag_in", {19'h0, e_j}, {19'h0, j_in});
      chk("flash_in", {16'h0, e_fl}, {16'h0, fl_in});
      chk("fast_in", {16'h0, e_fs}, {16'h0, fs_in});
      chk("uart_rx", {21'h0, func_sel[20] == 2'h0 ? pad_in[20] : 1'h1}, {21'h0, u_rx});
      chk("usb_in", {20'h0, usb_en ? {pad_in[19], pad_in[18]} : 2'h0}, {20'h0, usb_in});
   endtask

   // Counts and verdict; the only place the run ends
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Guard against a hang; counts as a mismatch
   initial begin
      #1000000;
      fail_count++;
      results();
   end

   // Main sequence
   initial begin
      repeat (2) @(posedge clock);
      @(negedge clock);
      chk("reset_oe_n", 22'h3FFFFF, pad_oe_n);
      chk("reset_pull", 22'h3FFFFF, {j_in, fl_in, fs_in, u_rx, 6'h3F});
      chk("reset_low", 22'h0, {m_in[21:2], usb_in});
      rst = 1'h0;
      $display("test reset done");
      // Every select value on all pads at once, including the refused value
      for (int k = 0; k < 4; k++) begin
         run_one(1'h1, k[1:0]);
      end
      $display("test uniform selects done");
      // Mixed selects, data and USB ownership
      repeat (150) begin
         run_one(1'h0, 2'h0);
      end
      $display("test random selects done");
      results();
   end
endmodule
